// ---- include/sep_consts.svh ----
// constants of the serial eeprom instruction port: opcodes, field sizes, timing counts
// assumes a single 100 MHz system clock on both ends
`ifndef SEP_CONSTS_SVH
`define SEP_CONSTS_SVH

`define SEP_CLK_NS       10
`define SEP_OP_SPECIAL   2'h0
`define SEP_OP_WRITE     2'h1
`define SEP_OP_READ      2'h2
`define SEP_OP_ERASE     2'h3
`define SEP_Q_WR_DIS     2'h0
`define SEP_Q_WR_ALL     2'h1
`define SEP_Q_ER_ALL     2'h2
`define SEP_Q_WR_EN      2'h3
`define SEP_ABITS_X8     5'h0b
`define SEP_ABITS_X16    5'h0a
`define SEP_DBITS_X8     5'h08
`define SEP_DBITS_X16    5'h10
`define SEP_ERASED       8'hff
`define SEP_MASK_X8      11'h7ff
`define SEP_MASK_X16     11'h3ff
// self-timed programming time, a plain default
`define SEP_T_PROG_NS    30000
`define SEP_PROG_CYC     ((`SEP_T_PROG_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
// serial clock half period, chip select low time, status valid time (least waits)
`define SEP_T_SKHALF_NS  250
`define SEP_SKHALF_CYC   ((`SEP_T_SKHALF_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`define SEP_T_CS_NS      250
`define SEP_CS_CYC       ((`SEP_T_CS_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)
`define SEP_T_SV_NS      400
`define SEP_SV_CYC       ((`SEP_T_SV_NS + `SEP_CLK_NS - 1) / `SEP_CLK_NS)

`endif

// ---- include/sep_pkg.sv ----
// types and field-size helpers shared by both ends of the instruction port
// assumes sep_consts.svh on the include path
`include "sep_consts.svh"

package sep_pkg;

   typedef enum logic [2:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_ERASE,
      CMD_WRITE_ENABLE,
      CMD_WRITE_DISABLE,
      CMD_WRITE_ALL,
      CMD_ERASE_ALL
   } sep_cmd_t;

   function automatic logic [4:0] sep_abits(input logic org);
      return org ? `SEP_ABITS_X16 : `SEP_ABITS_X8;
   endfunction : sep_abits

   function automatic logic [4:0] sep_dbits(input logic org);
      return org ? `SEP_DBITS_X16 : `SEP_DBITS_X8;
   endfunction : sep_dbits

endpackage : sep_pkg

// ---- include/sep_link_if.sv ----
// the three-wire serial link plus serial data out between host and device
// assumes both ends run off their own copy of one system clock
`timescale 1ns/1ps

interface sep_link_if;
   logic cs;
   logic sk;
   logic di;
   logic dout;

   modport dev  (input cs, input sk, input di, output dout);
   modport host (output cs, output sk, output di, input dout);
endinterface : sep_link_if

// ---- logic/sep_dev.sv ----
// device end: instruction decoder, read streamer, write protection,
// self-timed programming and ready/busy status of the serial eeprom
// assumes link pins are asynchronous to CLK; memory content is not reset
//
// Summary of operation
// - frame is start, opcode, address, optional data
// - sample input on serial clock rising edges
// - stopped serial clock freezes framing and read state
// - chip select low returns to standby
// - read loads word, emits dummy zero first
// - output changes on rising edges; read only
// - read continues upward, wraps at top
// - powers up write-disabled until enable
// - programming refused while write-disabled
// - host drops select before next clock
// - select falling starts self-timed programming
// - status low busy, high ready after select
// - status dropped if late or start bit
// - write-all fills every word with pattern
// - write-disable blocks programming until enable
// - host should disable writes after programming
// - erase starts on select fall, same status
// - erase-all sets every bit to one
// - opcodes 10,01,11; 00 qualified by address
// - organization pin picks byte or word
// - wrong bit count rejects all but read
`timescale 1ns/1ps
`include "sep_consts.svh"

module sep_dev
   import sep_pkg::*;
(
   input  wire logic CLK,
   input  wire logic RSTN,
   sep_link_if.dev   link,
   input  wire logic ORG,
   output wire logic WRITE_EN,
   output wire logic PROG_BUSY
);

   typedef enum logic [2:0] {
      ST_IDLE, ST_OPC, ST_ADDR, ST_DATA, ST_DONE, ST_READ
   } sep_dst_t;

   logic [7:0]  mem [0:2047];
   logic [3:0]  s1_r, s2_r, s3_r, pin_r;
   logic        skd_r, csd_r;
   sep_dst_t    st_r;
   logic [4:0]  cnt_r, rcnt_r;
   logic [1:0]  op_r;
   logic [10:0] addr_r, paddr_r;
   logic [15:0] data_r, pdata_r, sh_r;
   sep_cmd_t    cmd_r, pcmd_r;
   logic        extra_r, wen_r, busy_r, stat_r, do_r;
   logic [11:0] pcnt_r;

   logic        cs, di, org, rise, cs_fall, last_addr, read_next, exec;
   logic [4:0]  ab, db;
   logic [10:0] a_nxt, mask, a_inc;
   logic [1:0]  qual;
   logic        wr_all, wr_en;
   logic [10:0] wr_idx;
   logic [7:0]  wr_val;

   function automatic sep_cmd_t decode(input logic [1:0] op, input logic [1:0] q);
      sep_cmd_t c;
      c = CMD_READ;
      unique case (op)
         `SEP_OP_READ:  c = CMD_READ;
         `SEP_OP_WRITE: c = CMD_WRITE;
         `SEP_OP_ERASE: c = CMD_ERASE;
         `SEP_OP_SPECIAL: begin
            unique case (q)
               `SEP_Q_WR_EN:  c = CMD_WRITE_ENABLE;
               `SEP_Q_WR_ALL: c = CMD_WRITE_ALL;
               `SEP_Q_WR_DIS: c = CMD_WRITE_DISABLE;
               `SEP_Q_ER_ALL: c = CMD_ERASE_ALL;
            endcase
         end
      endcase
      return c;
   endfunction : decode

   // byte words sit left aligned so the streamer always shifts from bit 15
   function automatic logic [15:0] word_at(input logic [10:0] a, input logic o);
      return o ? {mem[{a[9:0], 1'b0}], mem[{a[9:0], 1'b1}]} : {mem[a], 8'h00};
   endfunction : word_at

   assign cs        = pin_r[0];
   assign di        = pin_r[2];
   assign org       = pin_r[3];
   assign rise      = pin_r[1] & ~skd_r & pin_r[0];
   assign cs_fall   = ~pin_r[0] & csd_r;
   assign ab        = sep_abits(org);
   assign db        = sep_dbits(org);
   assign mask      = org ? `SEP_MASK_X16 : `SEP_MASK_X8;
   assign a_nxt     = {addr_r[9:0], di} & mask;
   assign a_inc     = 11'(addr_r + 11'h001) & mask;
   assign qual      = org ? a_nxt[9:8] : a_nxt[10:9];
   assign last_addr = rise && st_r == ST_ADDR && cnt_r == 5'(ab - 5'h01);
   assign read_next = rise && st_r == ST_READ && rcnt_r == 5'h01;
   assign exec      = cs_fall && st_r == ST_DONE && !extra_r && !busy_r;
   assign WRITE_EN  = wen_r;
   assign PROG_BUSY = busy_r;
   assign link.dout = do_r;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser: a level counts once the second and third stages agree
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         s1_r  <= 4'h0;
         s2_r  <= 4'h0;
         s3_r  <= 4'h0;
         pin_r <= 4'h0;
         skd_r <= 1'b0;
         csd_r <= 1'b0;
      end else begin
         s1_r  <= {ORG, link.di, link.sk, link.cs};
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         pin_r <= (s2_r & ~(s2_r ^ s3_r)) | (pin_r & (s2_r ^ s3_r));
         skd_r <= pin_r[1];
         csd_r <= pin_r[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // instruction framing
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_r    <= ST_IDLE;
         cnt_r   <= 5'h00;
         op_r    <= 2'h0;
         addr_r  <= 11'h000;
         data_r  <= 16'h0000;
         cmd_r   <= CMD_READ;
         extra_r <= 1'b0;
      end else if (!cs) begin
         st_r    <= ST_IDLE;
         extra_r <= 1'b0;
      end else if (rise) begin
         unique case (st_r)
            ST_IDLE: begin
               if (di && !busy_r) begin
                  st_r  <= ST_OPC;
                  cnt_r <= 5'h00;
               end
            end
            ST_OPC: begin
               op_r  <= {op_r[0], di};
               cnt_r <= 5'(cnt_r + 5'h01);
               if (cnt_r == 5'h01) begin
                  st_r  <= ST_ADDR;
                  cnt_r <= 5'h00;
               end
            end
            ST_ADDR: begin
               addr_r <= a_nxt;
               cnt_r  <= 5'(cnt_r + 5'h01);
               if (last_addr) begin
                  cmd_r <= decode(op_r, qual);
                  cnt_r <= 5'h00;
                  if (op_r == `SEP_OP_READ)
                     st_r <= ST_READ;
                  else if (decode(op_r, qual) == CMD_WRITE ||
                           decode(op_r, qual) == CMD_WRITE_ALL)
                     st_r <= ST_DATA;
                  else
                     st_r <= ST_DONE;
               end
            end
            ST_DATA: begin
               data_r <= {data_r[14:0], di};
               cnt_r  <= 5'(cnt_r + 5'h01);
               if (cnt_r == 5'(db - 5'h01))
                  st_r <= ST_DONE;
            end
            ST_DONE: extra_r <= 1'b1;
            ST_READ: begin
               if (read_next)
                  addr_r <= a_inc;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial output: read stream, otherwise ready/busy status or idle high
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sh_r   <= 16'h0000;
         rcnt_r <= 5'h00;
         do_r   <= 1'b1;
      end else if (cs && last_addr && op_r == `SEP_OP_READ) begin
         sh_r   <= word_at(a_nxt, org);
         rcnt_r <= db;
         do_r   <= 1'b0;
      end else if (cs && rise && st_r == ST_READ) begin
         do_r   <= sh_r[15];
         sh_r   <= {sh_r[14:0], 1'b0};
         rcnt_r <= 5'(rcnt_r - 5'h01);
         if (read_next) begin
            sh_r   <= word_at(a_inc, org);
            rcnt_r <= db;
         end
      end else if (!(cs && st_r == ST_READ)) begin
         do_r <= (cs && stat_r) ? !busy_r : 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // write protection, programming timer, status flag
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wen_r   <= 1'b0;
         busy_r  <= 1'b0;
         stat_r  <= 1'b0;
         pcnt_r  <= 12'h000;
         pcmd_r  <= CMD_READ;
         paddr_r <= 11'h000;
         pdata_r <= 16'h0000;
      end else begin
         if (cs && rise && di && st_r == ST_IDLE)
            stat_r <= 1'b0;
         if (!cs && !busy_r)
            stat_r <= 1'b0;
         if (busy_r) begin
            pcnt_r <= 12'(pcnt_r + 12'h001);
            if (pcnt_r == 12'(`SEP_PROG_CYC - 1))
               busy_r <= 1'b0;
         end
         if (exec) begin
            unique case (cmd_r)
               CMD_WRITE_ENABLE:  wen_r <= 1'b1;
               CMD_WRITE_DISABLE: wen_r <= 1'b0;
               CMD_READ: ;
               default: begin
                  if (wen_r) begin
                     busy_r  <= 1'b1;
                     stat_r  <= 1'b1;                      // set wins over clear
                     pcnt_r  <= 12'h000;
                     pcmd_r  <= cmd_r;
                     paddr_r <= addr_r;
                     pdata_r <= data_r;
                  end
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // array update: one byte per cycle, so the whole-array forms need 2048 cycles
   always_comb begin
      wr_all = pcmd_r == CMD_WRITE_ALL || pcmd_r == CMD_ERASE_ALL;
      if (wr_all) begin
         wr_idx = pcnt_r[10:0];
         wr_en  = !pcnt_r[11];
      end else begin
         wr_idx = org ? {paddr_r[9:0], pcnt_r[0]} : paddr_r;
         wr_en  = org ? pcnt_r < 12'h002 : pcnt_r == 12'h000;
      end
      if (pcmd_r == CMD_ERASE || pcmd_r == CMD_ERASE_ALL)
         wr_val = `SEP_ERASED;
      else
         wr_val = (org && !wr_idx[0]) ? pdata_r[15:8] : pdata_r[7:0];
   end

   always_ff @(posedge CLK) begin
      if (busy_r && wr_en)
         mem[wr_idx] <= wr_val;
   end

endmodule : sep_dev

// ---- logic/sep_host.sv ----
// host end: turns user commands into framed instructions, clocks the link,
// polls ready/busy after programming and buffers read words in a FIFO
// assumes ORG is a static strap on CLK's domain; dout is asynchronous
`timescale 1ns/1ps
`include "sep_consts.svh"

module sep_fifo #(
   parameter int W = 16,
   parameter int D = 8
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         in_valid,
   output wire logic         in_ready,
   input  wire logic [W-1:0] in_data,
   output wire logic         out_valid,
   input  wire logic         out_ready,
   output wire logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   logic [W-1:0]  mem [0:D-1];
   logic [AW-1:0] wp_r, rp_r;
   logic [AW:0]   cnt_r;
   logic          push, pop, ov_r;

   assign in_ready  = cnt_r != (AW+1)'(D);
   assign out_valid = ov_r;
   assign out_data  = mem[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= '0;
         rp_r  <= '0;
         cnt_r <= '0;
         ov_r  <= 1'b0;
      end else begin
         if (push)
            wp_r <= AW'(wp_r + 1'b1);
         if (pop)
            rp_r <= AW'(rp_r + 1'b1);
         cnt_r <= (AW+1)'(cnt_r + push - pop);
         // flag kept in its own flop so the read port valid leaves a register
         ov_r  <= (AW+1)'(cnt_r + push - pop) != '0;
      end
   end

   always_ff @(posedge clk) begin
      if (push)
         mem[wp_r] <= in_data;
   end
endmodule : sep_fifo

module sep_host
   import sep_pkg::*;
(
   input  wire logic        CLK,
   input  wire logic        RSTN,
   sep_link_if.host         link,
   input  wire logic        ORG,
   input  wire logic        CMD_VALID,
   output wire logic        CMD_READY,
   input  wire sep_cmd_t    CMD_OP,
   input  wire logic [10:0] CMD_ADDR,
   input  wire logic [15:0] CMD_DATA,
   input  wire logic [7:0]  CMD_WORDS,
   output wire logic        RD_VALID,
   input  wire logic        RD_READY,
   output wire logic [15:0] RD_DATA
);
   typedef enum logic [1:0] {H_IDLE, H_CLOCK, H_CSLOW, H_POLL} sep_hst_t;

   sep_hst_t    st_r;
   logic        cs_r, sk_r, di_r, rdy_r, poll_r, first_r;
   logic [31:0] vec_r;
   logic [5:0]  ph_r, wait_r;
   logic [4:0]  cmd_left_r, wbit_r;
   logic [11:0] rd_left_r;
   logic [15:0] acc_r;
   logic [2:0]  d_r;
   logic        dout_f_r, half_end, sample, push, f_ready;
   logic [4:0]  ab, db;

   function automatic logic [31:0] frame(input sep_cmd_t c, input logic o,
                                         input logic [10:0] a, input logic [15:0] d);
      logic [31:0] v;
      logic [10:0] af;
      logic [4:0]  n;
      n = 5'(5'h03 + sep_abits(o));
      af = a;
      // start bit and the 00 opcode that the qualified commands share
      v = 32'h0000_0004;
      unique case (c)
         CMD_READ:          v = 32'h0000_0006;
         CMD_WRITE:         v = 32'h0000_0005;
         CMD_ERASE:         v = 32'h0000_0007;
         CMD_WRITE_ENABLE:  af = 11'({`SEP_Q_WR_EN, 9'h000} >> (11 - sep_abits(o)));
         CMD_WRITE_DISABLE: af = 11'({`SEP_Q_WR_DIS, 9'h000} >> (11 - sep_abits(o)));
         CMD_WRITE_ALL:     af = 11'({`SEP_Q_WR_ALL, 9'h000} >> (11 - sep_abits(o)));
         CMD_ERASE_ALL:     af = 11'({`SEP_Q_ER_ALL, 9'h000} >> (11 - sep_abits(o)));
      endcase
      v = (v << sep_abits(o)) | 32'(af & (o ? `SEP_MASK_X16 : `SEP_MASK_X8));
      if (c == CMD_WRITE || c == CMD_WRITE_ALL) begin
         v = (v << sep_dbits(o)) | 32'(o ? d : {8'h00, d[7:0]});
         n = 5'(n + sep_dbits(o));
      end
      return v << (6'd32 - 6'(n));
   endfunction : frame

   assign ab        = sep_abits(ORG);
   assign db        = sep_dbits(ORG);
   assign half_end  = st_r == H_CLOCK && ph_r == 6'(`SEP_SKHALF_CYC - 1);
   assign sample    = half_end && !sk_r && cmd_left_r == 5'h00 && !first_r;
   assign push      = sample && wbit_r == 5'(db - 5'h01);
   assign link.cs   = cs_r;
   assign link.sk   = sk_r;
   assign link.di   = di_r;
   assign CMD_READY = rdy_r;

   ////////////////////////////////////////////////////////////////////////////
   // dout synchroniser, same three-stage agree filter as the device pins
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         d_r      <= 3'h7;
         dout_f_r <= 1'b1;
      end else begin
         d_r <= {d_r[1:0], link.dout};
         if (d_r[1] == d_r[2])
            dout_f_r <= d_r[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // link sequencer; a full FIFO freezes the serial clock in its low half
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         st_r       <= H_IDLE;
         cs_r       <= 1'b0;
         sk_r       <= 1'b0;
         di_r       <= 1'b0;
         rdy_r      <= 1'b0;
         poll_r     <= 1'b0;
         first_r    <= 1'b0;
         vec_r      <= 32'h0000_0000;
         ph_r       <= 6'h00;
         wait_r     <= 6'h00;
         cmd_left_r <= 5'h00;
         rd_left_r  <= 12'h000;
      end else begin
         unique case (st_r)
            H_IDLE: begin
               rdy_r <= 1'b1;
               if (CMD_VALID && rdy_r) begin
                  rdy_r      <= 1'b0;
                  vec_r      <= frame(CMD_OP, ORG, CMD_ADDR, CMD_DATA) << 1;
                  di_r       <= 1'b1;
                  cs_r       <= 1'b1;
                  ph_r       <= 6'h00;
                  st_r       <= H_CLOCK;
                  first_r    <= CMD_OP == CMD_READ;
                  poll_r     <= !(CMD_OP inside {CMD_READ, CMD_WRITE_ENABLE,
                                                 CMD_WRITE_DISABLE});
                  cmd_left_r <= 5'(5'h03 + ab + ((CMD_OP == CMD_WRITE ||
                                 CMD_OP == CMD_WRITE_ALL) ? db : 5'h00));
                  rd_left_r  <= (CMD_OP == CMD_READ) ?
                                12'(12'(CMD_WORDS) * 12'(db) + 12'h001) : 12'h000;
               end
            end
            H_CLOCK: begin
               if (!half_end) begin
                  ph_r <= 6'(ph_r + 6'h01);
               end else if (!sk_r) begin
                  if (!(push && !f_ready)) begin
                     sk_r <= 1'b1;
                     ph_r <= 6'h00;
                     if (cmd_left_r == 5'h00)
                        first_r <= 1'b0;
                  end
               end else begin
                  sk_r  <= 1'b0;
                  ph_r  <= 6'h00;
                  di_r  <= vec_r[31];
                  vec_r <= vec_r << 1;
                  if (cmd_left_r != 5'h00)
                     cmd_left_r <= 5'(cmd_left_r - 5'h01);
                  else
                     rd_left_r <= 12'(rd_left_r - 12'h001);
                  if ((cmd_left_r == 5'h01 && rd_left_r == 12'h000) ||
                      (cmd_left_r == 5'h00 && rd_left_r == 12'h001)) begin
                     cs_r   <= 1'b0;
                     di_r   <= 1'b0;
                     wait_r <= 6'h00;
                     st_r   <= H_CSLOW;
                  end
               end
            end
            H_CSLOW: begin
               wait_r <= 6'(wait_r + 6'h01);
               if (wait_r == 6'(`SEP_CS_CYC - 1)) begin
                  wait_r <= 6'h00;
                  if (poll_r) begin
                     poll_r <= 1'b0;
                     cs_r   <= 1'b1;
                     st_r   <= H_POLL;
                  end else begin
                     st_r <= H_IDLE;
                  end
               end
            end
            H_POLL: begin
               if (wait_r != 6'(`SEP_SV_CYC))
                  wait_r <= 6'(wait_r + 6'h01);
               else if (dout_f_r) begin
                  cs_r <= 1'b0;
                  wait_r <= 6'h00;
                  st_r <= H_CSLOW;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read word assembly, the dummy zero after the address is not sampled (first_r)
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         wbit_r <= 5'h00;
         acc_r  <= 16'h0000;
      end else if (st_r == H_IDLE) begin
         wbit_r <= 5'h00;
      end else if (sample && !(push && !f_ready)) begin
         acc_r  <= {acc_r[14:0], dout_f_r};
         wbit_r <= push ? 5'h00 : 5'(wbit_r + 5'h01);
      end
   end

   sep_fifo #(.W(16), .D(8)) u_fifo (
      .clk       (CLK),
      .rst_n     (RSTN),
      .in_valid  (push),
      .in_ready  (f_ready),
      .in_data   (ORG ? {acc_r[14:0], dout_f_r} : {8'h00, acc_r[6:0], dout_f_r}),
      .out_valid (RD_VALID),
      .out_ready (RD_READY),
      .out_data  (RD_DATA)
   );

endmodule : sep_host

// ---- verif/sep_link_chk.sv ----
// link checker: timing of the serial pins, programming and status
// assumes one clock; cs, sk, di, dout come straight from the interface
`timescale 1ns/1ps

module sep_link_chk (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic cs,
   input wire logic sk,
   input wire logic di,
   input wire logic dout,
   input wire logic WRITE_EN,
   input wire logic PROG_BUSY
);
   int unsigned busy_cnt_r;
   int unsigned sel_cnt_r;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) busy_cnt_r <= 0;
      else busy_cnt_r <= PROG_BUSY ? busy_cnt_r + 1 : 0;
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) sel_cnt_r <= 0;
      else sel_cnt_r <= cs ? sel_cnt_r + 1 : 0;
   end

   ////////////////////////////////////////////////////////////
   sequence sel_low_s; !cs [*4]; endsequence
   sequence quiet_s; !cs [*8]; endsequence

   sel_edge_a: assert property ($changed(cs) |-> !sk)
      else $error("select moved while clock high");
   din_edge_a: assert property (cs && $changed(di) |-> !sk)
      else $error("data moved while clock high");
   prog_prot_a: assert property ($rose(PROG_BUSY) |-> $past(WRITE_EN) ##0 sel_low_s)
      else $error("programming without enable or select high");
   prog_len_a: assert property ($fell(PROG_BUSY) |-> busy_cnt_r inside {[2990:3010]})
      else $error("programming length off");
   prog_max_a: assert property (busy_cnt_r <= 3010)
      else $error("programming too long");
   busy_show_a: assert property (PROG_BUSY && sel_cnt_r > 41 |-> !dout)
      else $error("busy not shown");
   ready_show_a: assert property ($fell(PROG_BUSY) && cs |-> ##[0:45] dout)
      else $error("ready not shown");
   wen_change_a: assert property ($changed(WRITE_EN) |-> sel_low_s)
      else $error("enable changed outside select low");
   idle_out_a: assert property (quiet_s |=> dout)
      else $error("output not idle in standby");
endmodule : sep_link_chk

// ---- verif/testbench.sv ----
// bench: host and device ends joined, user side driven, read words scored
// assumes x16 strap until the last scenario, then x8; expected words queued before each read
`timescale 1ns/1ps

module testbench;
   import sep_pkg::*;
   logic clk = 0, rstn = 0, cmd_valid = 0, rd_ready = 0, stall = 0, org = 1;
   logic cmd_ready, rd_valid, wr_en, busy;
   sep_cmd_t cmd_op = CMD_READ;
   logic [10:0] cmd_addr = 0;
   logic [15:0] cmd_data = 0, rd_data, pat, val;
   logic [7:0] cmd_words = 0;
   logic [15:0] exp_q[$];
   int fail_count = 0, comparisons = 0;

   sep_link_if sep_link_if_inst ();
   sep_host sep_host_inst (.CLK(clk), .RSTN(rstn), .link(sep_link_if_inst), .ORG(org),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr),
      .CMD_DATA(cmd_data), .CMD_WORDS(cmd_words), .RD_VALID(rd_valid), .RD_READY(rd_ready),
      .RD_DATA(rd_data));
   sep_dev sep_dev_inst (.CLK(clk), .RSTN(rstn), .link(sep_link_if_inst), .ORG(org),
      .WRITE_EN(wr_en), .PROG_BUSY(busy));
   sep_link_chk sep_link_chk_inst (.CLK(clk), .RSTN(rstn), .cs(sep_link_if_inst.cs),
      .sk(sep_link_if_inst.sk), .di(sep_link_if_inst.di), .dout(sep_link_if_inst.dout),
      .WRITE_EN(wr_en), .PROG_BUSY(busy));

   initial forever #5 clk = ~clk;

   ////////////////////////////////////////////////////////////
   task automatic chk_word(logic [15:0] g, logic [15:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %0t read word %h not %h", $time, g, e);
      end
   endtask : chk_word

   task automatic chk_flag(logic g, logic e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %0t flag %b not %b", $time, g, e);
      end
   endtask : chk_flag

   task automatic idle();
      for (int i = 0; i < 20000 && cmd_ready !== 1'b1; i++) @(posedge clk) #1;
      chk_flag(cmd_ready, 1'b1);
   endtask : idle

   task automatic cmd(sep_cmd_t op, logic [10:0] a, logic [15:0] d, logic [7:0] n);
      cmd_op = op;
      cmd_addr = a;
      cmd_data = d;
      cmd_words = n;
      cmd_valid = 1;
      @(posedge clk) #1;
      cmd_valid = 0;
      repeat (2) @(posedge clk) #1;
   endtask : cmd

   task automatic op(sep_cmd_t o, logic [10:0] a, logic [15:0] d, logic [7:0] n);
      cmd(o, a, d, n);
      idle();
   endtask : op

   task automatic complete_run();
      if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : complete_run

   ////////////////////////////////////////////////////////////
   // random back-pressure; stall holds it off so the fifo fills
   always @(posedge clk) rd_ready <= #1 !stall && $urandom_range(1);

   always @(posedge clk) if (rd_valid === 1'b1 && rd_ready === 1'b1) begin
      chk_word(rd_data, exp_q.size() ? exp_q.pop_front() : 16'hxxxx);
   end

   initial begin
      #1000000;
      fail_count++;
      complete_run();
   end

   initial begin
      pat = $urandom(32'hc01b);
      pat = $urandom;
      val = $urandom;
      repeat (6) @(posedge clk);
      #1 rstn = 1;
      chk_flag(wr_en, 1'b0);
      idle();
      op(CMD_WRITE_ENABLE, 11'h000, 16'h0000, 0);
      chk_flag(wr_en, 1'b1);
      op(CMD_ERASE_ALL, 11'h000, 16'h0000, 0);
      repeat (12) exp_q.push_back(16'hffff);
      stall = 1;
      cmd(CMD_READ, 11'h3fc, 16'h0000, 12);
      // long enough for eight words to queue with the link paused
      repeat (8000) @(posedge clk) #1;
      stall = 0;
      idle();
      op(CMD_WRITE_ALL, 11'h000, pat, 0);
      op(CMD_WRITE, 11'h000, val, 0);
      exp_q.push_back(pat);
      exp_q.push_back(val);
      op(CMD_READ, 11'h3ff, 16'h0000, 2);
      op(CMD_ERASE, 11'h000, 16'h0000, 0);
      exp_q.push_back(16'hffff);
      op(CMD_READ, 11'h000, 16'h0000, 1);
      op(CMD_WRITE_DISABLE, 11'h000, 16'h0000, 0);
      chk_flag(wr_en, 1'b0);
      op(CMD_WRITE, 11'h001, ~pat, 0);
      exp_q.push_back(pat);
      op(CMD_READ, 11'h001, 16'h0000, 1);
      // byte organisation last: the x16 words now read back as byte pairs
      org = 0;
      op(CMD_WRITE_ENABLE, 11'h000, 16'h0000, 0);
      op(CMD_WRITE, 11'h7ff, val, 0);
      exp_q.push_back({8'h00, val[7:0]});
      exp_q.push_back(16'h00ff);
      exp_q.push_back(16'h00ff);
      exp_q.push_back({8'h00, pat[15:8]});
      op(CMD_READ, 11'h7ff, 16'h0000, 4);
      op(CMD_WRITE_DISABLE, 11'h000, 16'h0000, 0);
      chk_flag(wr_en, 1'b0);
      for (int i = 0; i < 2000 && exp_q.size() > 0; i++) @(posedge clk) #1;
      chk_flag(exp_q.size() == 0, 1'b1);
      complete_run();
   end
endmodule : testbench
